// ==== design/tohp_pkg.sv ====
package tohp_pkg;

    // Pin function selection of the transmit input port
    typedef enum logic [1:0] {
        TOHP_MODE_CLEAR,
        TOHP_MODE_HDLC,
        TOHP_MODE_PLCP
    } tohp_mode_e;

    // Byte-wide input message state
    typedef enum logic {
        TOHP_MSG_IDLE,
        TOHP_MSG_BUSY
    } tohp_msg_e;

    // Slots of the pin synchroniser vector
    localparam int SYNC_W   = 13;
    localparam int SI_TIC   = 0;
    localparam int SI_ROC   = 1;
    localparam int SI_OHBIT = 2;
    localparam int SI_OHREQ = 3;
    localparam int SI_SER   = 4;
    localparam int SI_DAT0  = 5;
    localparam int SI_DAT7  = 12;

    // Overhead bit spacing and count per outbound frame
    localparam logic [6:0] OH_PERIOD_M1   = 7'h54;
    localparam logic [6:0] OH_WIN_POS     = 7'h53;
    localparam logic [5:0] OH_PER_FRM_M1  = 6'h37;
    localparam logic [5:0] OH_FIRST_IDX   = 6'h00;

    // Demand clock divider, one eighth of the source clock
    localparam logic [2:0] DIV_LAST = 3'h7;
    localparam logic [2:0] DIV_HALF = 3'h3;

endpackage : tohp_pkg

// ==== design/tohp_sync_if.sv ====
`timescale 1ns/100ps
interface tohp_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    modport sync (input raw, output lvl, output rise, output fall);
    modport user (output raw, input lvl, input rise, input fall);
endinterface : tohp_sync_if

// ==== design/tohp_pin_sync.sv ====
`timescale 1ns/100ps
module tohp_pin_sync
    import tohp_pkg::*;
#(
    parameter int W = 1
)(
    input  wire logic   core_clk,   // Core clock
    input  wire logic   rst_b,      // Async reset, active low
    tohp_sync_if.sync   sif         // Raw pins in, clean levels out
);

    // Three-stage synchroniser per pin; level follows stages two and three
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic [2:0] sh_r;
        logic [2:0] sh_nxt;
        logic       lvl_r;
        logic       lvl_nxt;
        logic       rise_r;
        logic       rise_nxt;
        logic       fall_r;
        logic       fall_nxt;

        // Next shift state and filtered level
        always_comb
        begin
            sh_nxt   = {sh_r[1:0], sif.raw[i]};
            lvl_nxt  = (sh_r[1] == sh_r[2]) ? sh_r[2] : lvl_r;
            rise_nxt = lvl_nxt & ~lvl_r;
            fall_nxt = ~lvl_nxt & lvl_r;
        end

        // Register stage
        always_ff @(posedge core_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                sh_r   <= 3'h0;
                lvl_r  <= 1'b0;
                rise_r <= 1'b0;
                fall_r <= 1'b0;
            end
            else
            begin
                sh_r   <= sh_nxt;
                lvl_r  <= lvl_nxt;
                rise_r <= rise_nxt;
                fall_r <= fall_nxt;
            end
        end

        assign sif.lvl[i]  = lvl_r;
        assign sif.rise[i] = rise_r;
        assign sif.fall[i] = fall_r;
    end

endmodule : tohp_pin_sync

// ==== design/tohp_port.sv ====
`timescale 1ns/100ps
// How it works
// - Window output high one input-clock period just before overhead sampling.
// - Overhead bit latched on the input clock rise after the window.
// - HDLC mode: shared pins form a byte bus, bit seven is MSB.
// - HDLC byte bus sampled on rising edge of our demand clock.
// - Serial pin is payload, path overhead or send request by mode.
// - Clear-channel mode: serial input sampled on each input clock rise except the overhead bit position.
// - Demand clock is input or receive clock divided by eight.
// - Bytes latched while send request high, stop when it drops.
// - Frame pulse one period, with first overhead bit of frame.
module tohp_port
    import tohp_pkg::*;
(
    input  wire logic       core_clk,              // Core clock 20 MHz
    input  wire logic       rst_b,                 // Async reset
    input  wire logic       transmit_input_clock,  // Transmit clock pin
    input  wire logic       receive_output_clock,  // Loop-timing clock pin
    input  tohp_mode_e      mode,                  // Pin function select
    input  wire logic       loop_timing,           // Demand clock source
    input  wire logic       overhead_bit_in,       // External overhead bit
    input  wire logic       overhead_insert_request, // Insert request
    input  wire logic       payload_serial_in,     // Shared serial pin
    input  wire logic [6:0] hdlc_byte_in,          // Byte bus bits 6..0
    input  wire logic       hdlc_byte_in_msb,      // Shared pin, input side
    output logic            overhead_insert_window,   // Pin output value
    output logic            overhead_insert_window_oe_b, // Low = driving
    output logic            overhead_frame_pulse,  // Frame pulse/demand clk
    input  wire logic       internal_oh_bit,       // Generated overhead
    output logic            tx_bit,                // Outbound bit
    output logic            tx_bit_valid,          // Outbound bit strobe
    output logic            tx_bit_is_oh,          // Bit is an overhead bit
    output logic            plcp_poh_bit,          // Path overhead bit
    output logic            plcp_poh_valid,        // Path overhead strobe
    output logic [7:0]      hdlc_byte,             // Latched HDLC byte
    output logic            hdlc_byte_valid,       // HDLC byte strobe
    output logic            hdlc_msg_active,       // Message in progress
    output logic            hdlc_msg_end           // Message closed pulse
);

    tohp_sync_if #(.W(SYNC_W)) sif ();

    // Picks the overhead bit to send
    function automatic logic pick_oh(input logic req, input logic ext,
                                     input logic int_bit);
        pick_oh = req ? ext : int_bit;
    endfunction : pick_oh

    assign sif.raw = {hdlc_byte_in_msb, hdlc_byte_in, payload_serial_in,
                      overhead_insert_request, overhead_bit_in,
                      receive_output_clock, transmit_input_clock};

    tohp_pin_sync #(.W(SYNC_W)) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .sif      (sif)
    );

    logic       tic_rise;
    logic       src_edge;
    logic       is_hdlc;
    logic       dclk_rise;
    logic [6:0] bit_cnt_r, bit_cnt_nxt;
    logic [5:0] oh_idx_r, oh_idx_nxt;
    logic       win_r, win_nxt;
    logic       frm_r, frm_nxt;
    logic       oe_b_r, oe_b_nxt;
    logic [2:0] div_r, div_nxt;
    logic       dclk_r, dclk_nxt;
    logic       pin_r, pin_nxt;
    logic       txb_r, txb_nxt;
    logic       txv_r, txv_nxt;
    logic       txo_r, txo_nxt;
    logic       poh_r, poh_nxt;
    logic       pohv_r, pohv_nxt;
    logic [7:0] byte_r, byte_nxt;
    logic       bytev_r, bytev_nxt;
    logic       end_r, end_nxt;
    tohp_msg_e  msg_r, msg_nxt;

    // Edge selection for the overhead and demand clock timing
    assign tic_rise  = sif.rise[SI_TIC];
    assign is_hdlc   = (mode == TOHP_MODE_HDLC);
    assign src_edge  = is_hdlc &
                       (loop_timing ? sif.rise[SI_ROC] : tic_rise);
    assign dclk_rise = src_edge & (div_r == DIV_LAST);

    // Next-state computation for all port state
    always_comb
    begin
        bit_cnt_nxt = bit_cnt_r;
        oh_idx_nxt  = oh_idx_r;
        win_nxt     = win_r;
        frm_nxt     = frm_r;
        div_nxt     = div_r;
        dclk_nxt    = dclk_r;
        txb_nxt     = txb_r;
        txv_nxt     = 1'b0;
        txo_nxt     = txo_r;
        poh_nxt     = poh_r;
        pohv_nxt    = 1'b0;
        byte_nxt    = byte_r;
        bytev_nxt   = 1'b0;
        end_nxt     = 1'b0;
        msg_nxt     = msg_r;
        oe_b_nxt    = is_hdlc;
        if (!is_hdlc && tic_rise)
        begin
            // Window and frame pulse span one input clock period
            win_nxt = (bit_cnt_r == OH_WIN_POS);
            frm_nxt = (bit_cnt_r == OH_WIN_POS) &&
                      (oh_idx_r == OH_FIRST_IDX);
            txv_nxt = 1'b1;
            if (bit_cnt_r == OH_PERIOD_M1)
            begin
                bit_cnt_nxt = 7'h00;
                oh_idx_nxt  = (oh_idx_r == OH_PER_FRM_M1) ?
                              OH_FIRST_IDX : oh_idx_r + 6'h01;
                txo_nxt     = 1'b1;
                txb_nxt     = pick_oh(sif.lvl[SI_OHREQ], sif.lvl[SI_OHBIT],
                                      internal_oh_bit);
            end
            else
            begin
                bit_cnt_nxt = bit_cnt_r + 7'h01;
                txo_nxt     = 1'b0;
                txb_nxt     = sif.lvl[SI_SER];
                txv_nxt     = (mode == TOHP_MODE_CLEAR);
            end
            if (mode == TOHP_MODE_PLCP)
            begin
                poh_nxt  = sif.lvl[SI_SER];
                pohv_nxt = 1'b1;
            end
        end
        if (is_hdlc)
        begin
            win_nxt = 1'b0;
            frm_nxt = 1'b0;
            if (src_edge)
            begin
                div_nxt = div_r + 3'h1;
                if (div_r == DIV_LAST)
                    dclk_nxt = 1'b1;
                else if (div_r == DIV_HALF)
                    dclk_nxt = 1'b0;
            end
        end
        else
        begin
            div_nxt  = 3'h0;
            dclk_nxt = 1'b0;
        end
        // Message state: latch only while the send request is high
        case (msg_r)
            TOHP_MSG_IDLE:
            begin
                if (is_hdlc && dclk_rise && sif.lvl[SI_SER])
                begin
                    msg_nxt   = TOHP_MSG_BUSY;
                    byte_nxt  = sif.lvl[SI_DAT7:SI_DAT0];
                    bytev_nxt = 1'b1;
                end
            end
            TOHP_MSG_BUSY:
            begin
                if (!is_hdlc || !sif.lvl[SI_SER])
                begin
                    msg_nxt = TOHP_MSG_IDLE;
                    end_nxt = 1'b1;
                end
                else if (dclk_rise)
                begin
                    byte_nxt  = sif.lvl[SI_DAT7:SI_DAT0];
                    bytev_nxt = 1'b1;
                end
            end
            default: msg_nxt = TOHP_MSG_IDLE;
        endcase
        pin_nxt = is_hdlc ? dclk_nxt : frm_nxt;
    end

    // Register stage
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_cnt_r <= 7'h00;
            oh_idx_r  <= 6'h00;
            win_r     <= 1'b0;
            frm_r     <= 1'b0;
            oe_b_r    <= 1'b0;
            div_r     <= 3'h0;
            dclk_r    <= 1'b0;
            pin_r     <= 1'b0;
            txb_r     <= 1'b0;
            txv_r     <= 1'b0;
            txo_r     <= 1'b0;
            poh_r     <= 1'b0;
            pohv_r    <= 1'b0;
            byte_r    <= 8'h00;
            bytev_r   <= 1'b0;
            end_r     <= 1'b0;
            msg_r     <= TOHP_MSG_IDLE;
        end
        else
        begin
            bit_cnt_r <= bit_cnt_nxt;
            oh_idx_r  <= oh_idx_nxt;
            win_r     <= win_nxt;
            frm_r     <= frm_nxt;
            oe_b_r    <= oe_b_nxt;
            div_r     <= div_nxt;
            dclk_r    <= dclk_nxt;
            pin_r     <= pin_nxt;
            txb_r     <= txb_nxt;
            txv_r     <= txv_nxt;
            txo_r     <= txo_nxt;
            poh_r     <= poh_nxt;
            pohv_r    <= pohv_nxt;
            byte_r    <= byte_nxt;
            bytev_r   <= bytev_nxt;
            end_r     <= end_nxt;
            msg_r     <= msg_nxt;
        end
    end

    // Outputs straight from flops
    assign overhead_insert_window      = win_r;
    assign overhead_insert_window_oe_b = oe_b_r;
    assign overhead_frame_pulse        = pin_r;
    assign tx_bit          = txb_r;
    assign tx_bit_valid    = txv_r;
    assign tx_bit_is_oh    = txo_r;
    assign plcp_poh_bit    = poh_r;
    assign plcp_poh_valid  = pohv_r;
    assign hdlc_byte       = byte_r;
    assign hdlc_byte_valid = bytev_r;
    assign hdlc_msg_active = (msg_r == TOHP_MSG_BUSY);
    assign hdlc_msg_end    = end_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_oh_accept;
        !is_hdlc && tic_rise && (bit_cnt_r == OH_PERIOD_M1);
    endsequence

    a_window_one_period: assert property (
        win_r && !is_hdlc |=> (win_r != $past(tic_rise)))
        else $error("window not one input clock period");
    a_window_cause: assert property (
        $rose(win_r) |-> $past(tic_rise) && ($past(bit_cnt_r) == OH_WIN_POS))
        else $error("window rose at wrong bit position");
    a_oh_latch_ext: assert property (
        s_oh_accept ##0 sif.lvl[SI_OHREQ] |=>
        tx_bit_is_oh && tx_bit_valid && (tx_bit == $past(sif.lvl[SI_OHBIT])))
        else $error("external overhead bit not latched");
    a_oh_internal: assert property (
        s_oh_accept ##0 !sif.lvl[SI_OHREQ] |=>
        tx_bit_is_oh && (tx_bit == $past(internal_oh_bit)))
        else $error("internal overhead bit not used");
    a_byte_msb_order: assert property (
        hdlc_byte_valid |-> (hdlc_byte[7] == $past(sif.lvl[SI_DAT7])) &&
        (hdlc_byte[0] == $past(sif.lvl[SI_DAT0])))
        else $error("byte bus bit order wrong");
    a_byte_on_dclk: assert property (
        hdlc_byte_valid |-> $past(dclk_rise) ##1 overhead_frame_pulse)
        else $error("byte not taken on demand clock rise");
    a_pin_plcp_route: assert property (
        (mode == TOHP_MODE_PLCP) && tic_rise |=>
        plcp_poh_valid && (plcp_poh_bit == $past(sif.lvl[SI_SER])))
        else $error("path overhead pin not routed");
    a_payload_sample: assert property (
        (mode == TOHP_MODE_CLEAR) && tic_rise &&
        (bit_cnt_r != OH_PERIOD_M1) |=>
        tx_bit_valid && !tx_bit_is_oh &&
        (tx_bit == $past(sif.lvl[SI_SER])))
        else $error("payload bit not sampled");
    a_dclk_div_eight: assert property (
        is_hdlc && (dclk_r != $past(dclk_r)) |-> $past(src_edge) &&
        ($past(div_r) == (dclk_r ? DIV_LAST : DIV_HALF)))
        else $error("demand clock not divided by eight");
    a_send_stop: assert property (
        !sif.lvl[SI_SER] |=> !hdlc_byte_valid)
        else $error("byte latched without send request");
    a_frame_first_oh: assert property (
        !is_hdlc && $rose(frm_r) |-> $rose(win_r) && (oh_idx_r == OH_FIRST_IDX))
        else $error("frame pulse not at first overhead bit");

endmodule : tohp_port

// ==== sim/tohp_term.sv ====
`timescale 1ns/100ps
module tohp_term
    import tohp_pkg::*;
(
    input  wire logic       run,    // Clocks and traffic enable
    input  wire logic       ins_en, // Insert own overhead bits
    input  wire logic [3:0] hlen,   // Bytes per message
    input  tohp_mode_e      mode,   // Configured pin function
    input  wire logic       win,    // Overhead window pin
    input  wire logic       dclk,   // Demand clock pin
    output logic            tclk,   // Transmit input clock
    output logic            rclk,   // Receive output clock
    output logic            obit,   // Overhead bit
    output logic            oreq,   // Insert request
    output logic            ser,    // Shared serial pin
    output logic [7:0]      hbus    // Byte bus
);
    logic [7:0] pc;
    logic [3:0] hcnt;
    logic       hreq;
    logic       ohv;

    // Start values
    initial
    begin
        tclk = 1'b0;
        rclk = 1'b0;
        pc = 8'h00;
        obit = 1'b0;
        oreq = 1'b0;
        ohv = 1'b1;
        hbus = 8'h00;
    end

    // Clocks stop low when idle
    always #400 tclk = run & ~tclk;
    always #350 rclk = run & ~rclk;

    // Window sampled on falling edge, bit and request driven
    always @(negedge tclk)
    begin
        pc <= pc + 8'h01;
        if (mode != TOHP_MODE_HDLC && win && ins_en)
        begin
            obit <= ohv;
            oreq <= 1'b1;
            ohv <= ~ohv;
        end
        else
        begin
            oreq <= 1'b0;
            obit <= ~obit; // Released: not the last value
        end
    end

    // Payload or send request on the shared pin
    assign ser = (mode == TOHP_MODE_HDLC) ? hreq : pc[0] ^ pc[2];

    // Byte bus changes on demand clock fall, bit 7 on msb
    always @(negedge dclk or negedge run)
    if (!run)
    begin
        hcnt <= 4'h0;
        hreq <= 1'b0;
    end
    else if (mode == TOHP_MODE_HDLC)
    begin
        if (hcnt < hlen)
        begin
            hbus <= 8'hC3 + 8'h3B * {4'h0, hcnt};
            hreq <= 1'b1;
            hcnt <= hcnt + 4'h1;
        end
        else
        begin
            hreq <= 1'b0;
            hbus <= ~hbus;
        end
    end
endmodule : tohp_term

// ==== sim/tx_overhead_payload_input_port_test.sv ====
`timescale 1ns/100ps
module tx_overhead_payload_input_port_test
    import tohp_pkg::*;
;
    logic       core_clk, rst_b, ioh, run, ins_en, lt;
    tohp_mode_e mode;
    logic [3:0] hlen;
    logic       tclk, rclk, obit, oreq, ser, pin7, win, oe_b, fp;
    logic [7:0] hbus, hbyte;
    logic       txb, txv, txo, pb, pv, hv, act, mend;
    int         num_errors, check_count, k, hidx;
    logic [1:0] q_tx[$];
    logic       q_ser[$];

    // Core clock
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Shared window / bit 7 pin
    assign pin7 = oe_b ? hbus[7] : win;

    tohp_port DUT (.core_clk(core_clk), .rst_b(rst_b),
        .transmit_input_clock(tclk), .receive_output_clock(rclk),
        .mode(mode), .loop_timing(lt), .overhead_bit_in(obit),
        .overhead_insert_request(oreq), .payload_serial_in(ser),
        .hdlc_byte_in(hbus[6:0]), .hdlc_byte_in_msb(pin7),
        .overhead_insert_window(win), .overhead_insert_window_oe_b(oe_b),
        .overhead_frame_pulse(fp), .internal_oh_bit(ioh), .tx_bit(txb),
        .tx_bit_valid(txv), .tx_bit_is_oh(txo), .plcp_poh_bit(pb),
        .plcp_poh_valid(pv), .hdlc_byte(hbyte), .hdlc_byte_valid(hv),
        .hdlc_msg_active(act), .hdlc_msg_end(mend));

    tohp_term TERM (.run(run), .ins_en(ins_en), .hlen(hlen), .mode(mode),
        .win(pin7), .dclk(fp), .tclk(tclk), .rclk(rclk), .obit(obit),
        .oreq(oreq), .ser(ser), .hbus(hbus));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // Expected outbound bits; position 84 of every 85 is overhead
    always @(posedge tclk)
    if (rst_b && mode != TOHP_MODE_HDLC)
    begin
        if (k % 85 == 84)
            q_tx.push_back({1'b1, ins_en ? obit : ioh});
        else if (mode == TOHP_MODE_CLEAR)
            q_tx.push_back({1'b0, ser});
        if (mode == TOHP_MODE_PLCP)
            q_ser.push_back(ser);
        k++;
    end

    // Window and frame pulse as the terminal sees them
    always @(negedge tclk)
    if (rst_b && mode != TOHP_MODE_HDLC)
    begin
        chk(win, k % 85 == 84);
        chk(fp, k % 85 == 84 && (k / 85) % 56 == 0);
        chk(oe_b, 1'b0);
    end

    // Outbound and path overhead bits judged against the queues, HDLC bytes against the pattern, mid-cycle once settled
    always @(negedge core_clk)
    if (rst_b)
    begin
        if (txv && q_tx.size() == 0)
            chk(8'hFF, 8'h00);
        else if (txv)
            chk({txo, txb}, q_tx.pop_front());
        if (pv && q_ser.size() == 0)
            chk(8'hFF, 8'h00);
        else if (pv)
            chk(pb, q_ser.pop_front());
        if (hv)
        begin
            chk(hbyte, 8'hC3 + 8'h3B * hidx[7:0]);
            hidx++;
        end
    end

    // Stop clocks, reset, set mode, restart
    task automatic start(input tohp_mode_e m, input logic l, input logic i);
        run <= 1'b0;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b0;
        mode <= m;
        lt <= l;
        ins_en <= i;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        q_tx.delete();
        q_ser.delete();
        k = 0;
        hidx = 0;
        repeat (4) @(posedge core_clk);
        run <= 1'b1;
    endtask : start

    // Run n rises then see every expected bit was delivered
    task automatic drain(input int n);
        while (k < n)
            @(posedge core_clk);
        run <= 1'b0;
        repeat (30) @(posedge core_clk);
        chk(8'(q_tx.size() + q_ser.size()), 8'h00);
    endtask : drain

    task automatic t_clear_insert;
        ioh <= 1'b0;
        start(TOHP_MODE_CLEAR, 1'b0, 1'b1);
        drain(172);
    endtask : t_clear_insert

    task automatic t_clear_internal;
        ioh <= 1'b1;
        start(TOHP_MODE_CLEAR, 1'b0, 1'b0);
        drain(88);
    endtask : t_clear_internal

    task automatic t_plcp;
        start(TOHP_MODE_PLCP, 1'b0, 1'b0);
        drain(40);
    endtask : t_plcp

    // Five-byte message, demand clock period from chosen source
    task automatic t_hdlc(input logic l, input logic [7:0] per);
        time t0;
        int  c;
        start(TOHP_MODE_HDLC, l, 1'b0);
        @(posedge fp);
        t0 = $time;
        @(posedge fp);
        @(negedge core_clk);
        chk(8'(($time - t0) / 50), per);
        chk(act, 1'b1);
        chk(oe_b, 1'b1);
        for (c = 0; c < 3000 && mend !== 1'b1; c++)
            @(negedge core_clk);
        chk(mend, 1'b1);
        chk(act, 1'b0);
        repeat (300) @(negedge core_clk);
        chk(8'(hidx), 8'h05);
    endtask : t_hdlc

    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        mode = TOHP_MODE_CLEAR;
        lt = 1'b0;
        ioh = 1'b0;
        run = 1'b0;
        ins_en = 1'b0;
        hlen = 4'h5;
        num_errors = 0;
        check_count = 0;
        k = 0;
        hidx = 0;
        repeat (12) @(posedge core_clk);
        t_clear_insert();
        t_clear_internal();
        t_plcp();
        t_hdlc(1'b0, 8'h80);
        t_hdlc(1'b1, 8'h70);
        finish_test();
    end

    // Watchdog
    initial
    begin
        #1000000;
        num_errors++;
        finish_test();
    end
endmodule : tx_overhead_payload_input_port_test
